// [design/fid_pkg.sv]
// package: shared constants for the transmit function-id sideband
`default_nettype none
package fid_pkg;
    // ************************************************************
    // field widths
    // ************************************************************
    localparam int PF_W = 2;
    localparam int VF_W = 11;
    localparam int DCRED_W = 12;
    localparam int HCRED_W = 8;
    localparam int SEL_W = 2;
    localparam int MAX_VFS = 2048;
    localparam int CREDIT_BYTES = 16;
    localparam int SEL_LATENCY = 2;
    // ************************************************************
    // credit class encodings
    // ************************************************************
    localparam logic [1:0] SEL_POSTED = 2'h0;
    localparam logic [1:0] SEL_NONPOSTED = 2'h1;
    localparam logic [1:0] SEL_COMPLETION = 2'h2;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [1:0] PF_RESET = 2'h0;
    localparam logic [10:0] VF_RESET = 11'h000;
    localparam logic [11:0] DCRED_RESET = 12'h000;
    localparam logic [7:0] HCRED_RESET = 8'h00;
    // ************************************************************
    // stream carried through the two-entry buffer: {pf, vf_flag, vf}
    // ************************************************************
    localparam int WORD_W = PF_W + 1 + VF_W;
endpackage
`default_nettype wire

// [design/fid_if.sv]
// interface: sideband wires between application end and bridge end
`default_nettype none
interface fid_if;
    logic tx_packet_start;
    logic tx_beat_valid;
    logic tx_sink_ready;
    logic [1:0] tx_phys_func_id;
    logic tx_virt_func_flag;
    logic [10:0] tx_virt_func_offset;
    logic [1:0] credit_class_select;
    logic [11:0] data_credit_limit;
    logic [7:0] header_credit_limit;

    modport app (
        output tx_packet_start, tx_beat_valid, tx_phys_func_id,
        output tx_virt_func_flag, tx_virt_func_offset, credit_class_select,
        input tx_sink_ready, data_credit_limit, header_credit_limit
    );
    modport bridge (
        input tx_packet_start, tx_beat_valid, tx_phys_func_id,
        input tx_virt_func_flag, tx_virt_func_offset, credit_class_select,
        output tx_sink_ready, data_credit_limit, header_credit_limit
    );
endinterface
`default_nettype wire

// [design/fid_skid_buffer.sv]
// module: two-entry valid/ready buffer
`default_nettype none
module fid_skid_buffer #(
    parameter int WIDTH = 14
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [2];
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    // honest full and empty from the occupancy count
    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready && clk_en;
    assign pop = out_valid && out_ready && clk_en;

    // storage write, no reset needed on data words
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop) begin
                count <= count + 2'h1;
            end else if (pop && !push) begin
                count <= count - 2'h1;
            end
        end
    end
endmodule // fid_skid_buffer
`default_nettype wire

// [design/fid_bridge.sv]
// module: bridge end that captures function ids and reports credit limits
`default_nettype none
// Operation
// - application drives 2-bit physical function id
// - virtual function tlps carry owning pf id
// - capture pf id on start and valid
// - application flags virtual function tlps
// - sample vf flag on start and valid
// - application drives 11-bit vf offset
// - vf offset below count, 2048 max
// - sample offset at start; ignore for pf
// - 12-bit data credit limit, 16-byte units
// - credits follow select two cycles later
// - select 00 posted, 01 np, 10 cpl
// - valid held whole tlp except ready drop
module fid_bridge #(
    parameter int NUM_VFS = 2048
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // link to application
    fid_if.bridge link,
    // credit limits from the flow-control tracker
    input wire logic [11:0] posted_data_credit,
    input wire logic [11:0] nonposted_data_credit,
    input wire logic [11:0] completion_data_credit,
    input wire logic [7:0] posted_header_credit,
    input wire logic [7:0] nonposted_header_credit,
    input wire logic [7:0] completion_header_credit,
    // captured identification towards the header builder
    output logic id_valid,
    input wire logic id_ready,
    output logic [1:0] pkt_phys_func_id,
    output logic pkt_virt_func_flag,
    output logic [10:0] pkt_virt_func_offset,
    output logic [1:0] held_phys_func_id,
    output logic held_virt_func_flag,
    output logic [10:0] held_virt_func_offset,
    output logic offset_range_error
);
    // ************************************************************
    // internal signals
    // ************************************************************
    // capture qualifiers
    logic start_offered;
    logic start_beat;
    logic buf_in_ready;
    // identification word entering and leaving the queue
    logic [10:0] next_offset;
    logic [fid_pkg::WORD_W-1:0] buf_in;
    logic [fid_pkg::WORD_W-1:0] buf_out;
    // range check on the offered offset
    logic offset_too_big;
    // credit pipeline stages
    logic [1:0] sel_d1;
    logic [11:0] data_stage;
    logic [7:0] hdr_stage;

    // ************************************************************
    // decode helpers
    // ************************************************************
    // data limit of one class; the spare code reads zero, never a stale class
    function automatic logic [11:0] data_credit_of(input logic [1:0] sel,
            input logic [11:0] pd, input logic [11:0] nd, input logic [11:0] cd);
        logic [11:0] r;
        r = fid_pkg::DCRED_RESET;
        unique case (sel)
            fid_pkg::SEL_POSTED: r = pd;
            fid_pkg::SEL_NONPOSTED: r = nd;
            fid_pkg::SEL_COMPLETION: r = cd;
            default: r = fid_pkg::DCRED_RESET;
        endcase
        return r;
    endfunction

    // header limit of one class, decoded exactly as the data side
    function automatic logic [7:0] header_credit_of(input logic [1:0] sel,
            input logic [7:0] ph, input logic [7:0] nh, input logic [7:0] ch);
        logic [7:0] r;
        r = fid_pkg::HCRED_RESET;
        unique case (sel)
            fid_pkg::SEL_POSTED: r = ph;
            fid_pkg::SEL_NONPOSTED: r = nh;
            fid_pkg::SEL_COMPLETION: r = ch;
            default: r = fid_pkg::HCRED_RESET;
        endcase
        return r;
    endfunction

    // offsets at or above the attached vf count name no function
    function automatic logic offset_outside(input logic [10:0] off);
        return {21'h0, off} >= 32'(NUM_VFS);
    endfunction

    // ************************************************************
    // identification capture
    // ************************************************************
    // offered on sop with valid
    assign start_offered = link.tx_packet_start && link.tx_beat_valid;
    // taken only when the queue has room
    assign start_beat = start_offered && buf_in_ready;
    // the queue's space is the ready, so a refused start is simply held by the sender
    assign link.tx_sink_ready = buf_in_ready;
    // a pf tlp's offset is ignored and stored as zero
    assign next_offset = link.tx_virt_func_flag ? link.tx_virt_func_offset
                                                : fid_pkg::VF_RESET;
    // only a flagged tlp's offset can be out of range
    assign offset_too_big = link.tx_virt_func_flag
                            && offset_outside(link.tx_virt_func_offset);

    // held pf id persists until the next start beat
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            held_phys_func_id <= fid_pkg::PF_RESET;
        end else if (clk_en && start_beat) begin
            held_phys_func_id <= link.tx_phys_func_id;
        end
    end

    // held vf flag, captured on the same beat as the pf id
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            held_virt_func_flag <= 1'b0;
        end else if (clk_en && start_beat) begin
            held_virt_func_flag <= link.tx_virt_func_flag;
        end
    end

    // held offset; a pf tlp leaves zero here rather than a stale vf offset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            held_virt_func_offset <= fid_pkg::VF_RESET;
        end else if (clk_en && start_beat) begin
            held_virt_func_offset <= next_offset;
        end
    end

    // sticky error flag for a flagged offset past the vf count
    // only reset clears it, so a one-beat event is never lost
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            offset_range_error <= 1'b0;
        end else if (clk_en && start_beat && offset_too_big) begin
            offset_range_error <= 1'b1;
        end
    end

    // ************************************************************
    // per-packet id queue
    // ************************************************************
    // ids packed {pf, flag, offset}, unpacked in the same order below
    assign buf_in = {link.tx_phys_func_id, link.tx_virt_func_flag,
                     next_offset};

    // two entries let a stalled header builder lose no id
    fid_skid_buffer #(.WIDTH(fid_pkg::WORD_W)) u_buf (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .in_valid(start_offered),
        .in_ready(buf_in_ready),
        .in_data(buf_in),
        .out_valid(id_valid),
        .out_ready(id_ready),
        .out_data(buf_out)
    );
    // queued ids towards the header builder
    assign {pkt_phys_func_id, pkt_virt_func_flag, pkt_virt_func_offset} = buf_out;

    // ************************************************************
    // credit limit reporting
    // ************************************************************
    // first stage: select sampled; the value stage behind it gives the two cycles
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_d1 <= fid_pkg::SEL_POSTED;
        end else if (clk_en) begin
            sel_d1 <= link.credit_class_select;
        end
    end

    // second stage: data limit of the class held in the first stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_stage <= fid_pkg::DCRED_RESET;
        end else if (clk_en) begin
            data_stage <= data_credit_of(sel_d1,
                posted_data_credit, nonposted_data_credit,
                completion_data_credit);
        end
    end

    // second stage: header limit, kept in step with the data limit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hdr_stage <= fid_pkg::HCRED_RESET;
        end else if (clk_en) begin
            hdr_stage <= header_credit_of(sel_d1,
                posted_header_credit, nonposted_header_credit,
                completion_header_credit);
        end
    end

    // limits leave straight from the value stage registers
    assign link.data_credit_limit = data_stage;
    assign link.header_credit_limit = hdr_stage;
endmodule // fid_bridge
`default_nettype wire

// [design/fid_app.sv]
// module: application end that drives packets and function ids
`default_nettype none
module fid_app #(
    parameter int NUM_VFS = 2048
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // link to bridge
    fid_if.app link,
    // user request: one beat per accepted request
    input wire logic beat_req,
    input wire logic beat_first,
    output logic beat_ack,
    input wire logic [1:0] user_phys_func_id,
    input wire logic user_virt_func_flag,
    input wire logic [10:0] user_virt_func_offset,
    input wire logic [1:0] user_credit_select,
    // credit readback
    output logic [11:0] user_data_credit,
    output logic [7:0] user_header_credit
);
    logic [1:0] pf;
    logic flag;
    logic [10:0] off;
    logic start;
    logic valid;
    logic [1:0] sel;

    // beat stands until the sink accepts; valid drops only with ready high
    assign beat_ack = valid && link.tx_sink_ready;
    assign link.tx_beat_valid = valid;
    assign link.tx_packet_start = start;
    assign link.tx_phys_func_id = pf;
    assign link.tx_virt_func_flag = flag;
    assign link.tx_virt_func_offset = off;
    assign link.credit_class_select = sel;

    // load a new beat when idle or the previous one was taken
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            valid <= 1'b0;
            start <= 1'b0;
            pf <= fid_pkg::PF_RESET;
            flag <= 1'b0;
            off <= fid_pkg::VF_RESET;
        end else if (clk_en && (!valid || link.tx_sink_ready)) begin
            valid <= beat_req;
            start <= beat_req && beat_first;
            pf <= user_phys_func_id;
            flag <= user_virt_func_flag;
            // offsets at or above the vf count become zero; zero for pf tlps
            off <= (user_virt_func_flag && ({21'h0, user_virt_func_offset} < 32'(NUM_VFS)))
                   ? user_virt_func_offset : fid_pkg::VF_RESET;
        end
    end

    // select and credit readback registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sel <= fid_pkg::SEL_POSTED;
            user_data_credit <= fid_pkg::DCRED_RESET;
            user_header_credit <= fid_pkg::HCRED_RESET;
        end else if (clk_en) begin
            sel <= user_credit_select;
            user_data_credit <= link.data_credit_limit;
            user_header_credit <= link.header_credit_limit;
        end
    end
endmodule // fid_app
`default_nettype wire

// [tb/fid_sideband_chk.sv]
// checker: wire-level properties of the function-id sideband
`default_nettype none
module fid_sideband_chk (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // sideband wires
    input wire logic tx_packet_start,
    input wire logic tx_beat_valid,
    input wire logic tx_sink_ready,
    input wire logic [1:0] tx_phys_func_id,
    input wire logic tx_virt_func_flag,
    input wire logic [10:0] tx_virt_func_offset,
    input wire logic [1:0] credit_class_select,
    input wire logic [11:0] data_credit_limit,
    input wire logic [7:0] header_credit_limit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] age;
    // edges since reset: $past looks three back, so wait for clean history
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            age <= 3'h0;
        end else if (age != 3'h4) begin
            age <= age + 3'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_CRED_DATA: assert property (age == 3'h4 && data_credit_limit != $past(data_credit_limit)
        |-> $past(credit_class_select, 2) != $past(credit_class_select, 3))
        else $error("data limit moved without select change");
    AST_CRED_HDR: assert property (age == 3'h4 && $changed(header_credit_limit)
        |-> $past(credit_class_select, 2) != $past(credit_class_select, 3))
        else $error("header limit moved without select change");
    AST_CRED_SPARE: assert property (age == 3'h4 && $past(credit_class_select, 2) == 2'h3
        |-> data_credit_limit == 12'h000 && header_credit_limit == 8'h00)
        else $error("unused select gave nonzero limits");
    AST_CRED_LIVE: assert property (age == 3'h4 && $past(credit_class_select, 3) == 2'h3
        && $past(credit_class_select, 2) != 2'h3 |-> data_credit_limit != 12'h000)
        else $error("data limit not presented");
    AST_READY_FELL: assert property ($fell(tx_sink_ready)
        |-> $past(tx_packet_start && tx_beat_valid && tx_sink_ready))
        else $error("ready dropped without a captured start");
    AST_SOP_VALID: assert property (tx_packet_start |-> tx_beat_valid)
        else $error("start without valid");
    AST_APP_HOLD: assert property (tx_beat_valid && !tx_sink_ready |=> tx_beat_valid
        && $stable({tx_packet_start, tx_phys_func_id, tx_virt_func_flag, tx_virt_func_offset}))
        else $error("refused beat not held");
    // main scenarios reached
    cover property (tx_beat_valid && !tx_sink_ready);
    cover property (tx_packet_start && tx_virt_func_flag && tx_sink_ready);
    cover property ($past(credit_class_select, 2) == 2'h3);
endmodule // fid_sideband_chk
`default_nettype wire

// [tb/tb_tx_function_id_sideband.sv]
// testbench: application end and bridge end joined by the sideband
`default_nettype none
module tb_tx_function_id_sideband;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, beat_req, beat_first, id_ready, u_flag, id_valid, h_flag, p_flag, rng;
    logic clk_en, ack;
    logic [1:0] u_pf, u_sel, h_pf, p_pf;
    logic [10:0] u_off, h_off, p_off;
    logic [11:0] dcr [3];
    logic [7:0] hcr [3];
    logic [11:0] ud;
    logic [7:0] uh;
    int err_count = 0;
    int checked = 0;
    fid_if link();
    // app's vf count above the bridge's, so the bridge's range flag can be reached
    fid_app #(.NUM_VFS(16)) u_fid_app (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .link(link), .beat_req(beat_req), .beat_first(beat_first), .beat_ack(ack),
        .user_phys_func_id(u_pf), .user_virt_func_flag(u_flag), .user_virt_func_offset(u_off),
        .user_credit_select(u_sel), .user_data_credit(ud), .user_header_credit(uh));
    fid_bridge #(.NUM_VFS(8)) u_fid_bridge (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .link(link), .posted_data_credit(dcr[0]), .nonposted_data_credit(dcr[1]),
        .completion_data_credit(dcr[2]), .posted_header_credit(hcr[0]),
        .nonposted_header_credit(hcr[1]), .completion_header_credit(hcr[2]),
        .id_valid(id_valid), .id_ready(id_ready), .pkt_phys_func_id(p_pf),
        .pkt_virt_func_flag(p_flag), .pkt_virt_func_offset(p_off), .held_phys_func_id(h_pf),
        .held_virt_func_flag(h_flag), .held_virt_func_offset(h_off), .offset_range_error(rng));
    fid_sideband_chk u_fid_sideband_chk (.clk(clk), .reset_n(reset_n),
        .tx_packet_start(link.tx_packet_start), .tx_beat_valid(link.tx_beat_valid),
        .tx_sink_ready(link.tx_sink_ready), .tx_phys_func_id(link.tx_phys_func_id),
        .tx_virt_func_flag(link.tx_virt_func_flag), .tx_virt_func_offset(link.tx_virt_func_offset),
        .credit_class_select(link.credit_class_select), .data_credit_limit(link.data_credit_limit),
        .header_credit_limit(link.header_credit_limit));
    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // select 11 has no class behind it, so zero is expected
    function automatic logic [11:0] xd(input logic [1:0] s);
        return (s == 2'h3) ? 12'h000 : dcr[s];
    endfunction
    function automatic logic [7:0] xh(input logic [1:0] s);
        return (s == 2'h3) ? 8'h00 : hcr[s];
    endfunction
    // request held high across the list: one beat a cycle, {first, pf, flag, offset}
    task automatic send(input logic [14:0] q[$]);
        beat_req = 1'b1;
        foreach (q[i]) begin
            {beat_first, u_pf, u_flag, u_off} = q[i];
            cyc(1);
        end
        beat_req = 1'b0;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_credit();
        logic [1:0] prev;
        for (int s = 3; s >= 0; s--) begin
            prev = u_sel;
            u_sel = 2'(s);
            cyc(2);
            chk(16'(link.data_credit_limit), 16'(xd(prev)), "early");
            cyc(1);
            chk(16'(link.data_credit_limit), 16'(xd(u_sel)), "data");
            chk(16'(link.header_credit_limit), 16'(xh(u_sel)), "hdr");
            cyc(1);
            chk(16'(ud), 16'(xd(u_sel)), "user data");
            chk(16'(uh), 16'(xh(u_sel)), "user hdr");
        end
    endtask
    task automatic t_ids();
        id_ready = 1'b1;
        send('{15'h6805, 15'h1003});
        cyc(3);
        chk(16'({h_pf, h_flag, h_off}), 16'h2805, "held vf");
        send('{15'h7006});
        cyc(3);
        chk(16'({h_pf, h_flag, h_off}), 16'h3000, "held pf");
    endtask
    // bridge queue full: third start refused and held until the first queued id drains
    task automatic t_stall();
        logic [13:0] w[3] = '{14'h0801, 14'h1802, 14'h2000};
        id_ready = 1'b0;
        send('{15'h4801, 15'h5802, 15'h6004});
        cyc(1);
        chk(16'(link.tx_sink_ready), 16'h0000, "ready");
        chk(16'(ack), 16'h0000, "ack stalled");
        chk(16'({h_pf, h_flag, h_off}), 16'h1802, "held stall");
        id_ready = 1'b1;
        foreach (w[i]) begin
            chk(16'({id_valid, p_pf, p_flag, p_off}), 16'(w[i]) | 16'h4000, "pkt");
            cyc(1);
        end
        chk(16'(id_valid), 16'h0000, "drained");
        chk(16'({h_pf, h_flag, h_off}), 16'h2000, "held last");
    endtask
    // enable low freezes both ends: a select change waits for the enable
    task automatic t_freeze();
        clk_en = 1'b0;
        u_sel = 2'h1;
        cyc(4);
        chk(16'(link.data_credit_limit), 16'(xd(2'h0)), "frozen");
        clk_en = 1'b1;
        cyc(3);
        chk(16'(link.data_credit_limit), 16'(xd(2'h1)), "thawed");
    endtask
    // offset 8 passes the app (16 vfs) and trips the bridge (8); 16 is masked by the app
    task automatic t_range();
        send('{15'h5807});
        chk(16'(ack), 16'h0001, "ack");
        cyc(3);
        chk(16'(rng), 16'h0000, "in range");
        send('{15'h5808});
        cyc(3);
        chk(16'(rng), 16'h0001, "out of range");
        send('{15'h5810});
        cyc(3);
        chk(16'({h_pf, h_flag, h_off}), 16'h1800, "masked");
    endtask
    // ************************************************************
    // clock, watchdog and main sequence
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        $display("FAIL %0t run too long", $time);
        end_sim();
    end
    initial begin
        reset_n = 1'b0;
        {beat_req, beat_first, id_ready, u_flag, u_pf, u_sel, u_off} = '0;
        clk_en = 1'b1;
        dcr = '{12'h111, 12'h222, 12'h333};
        hcr = '{8'h44, 8'h55, 8'h66};
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        cyc(4);
        t_credit();
        t_freeze();
        t_ids();
        t_stall();
        t_range();
        end_sim();
    end
endmodule // tb_tx_function_id_sideband
`default_nettype wire
